// >>> src/hsp_top.sv
`timescale 1ns/10ps
module hsp_top
  import hsp_pkg::*;
(
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_SYS_RST,
  // UART pins
  input wire logic I_UART_RX,
  output logic O_UART_TX,
  input wire logic I_UART_CTS_N,
  output logic O_UART_RTS_N,
  // SPI host pins, sampled on core clock
  input wire logic I_SPI_CLK,
  input wire logic I_HOST_PORT_SELECT_N,
  input wire logic I_SPI_MOSI,
  output logic O_SPI_MISO,
  // Host control pins
  output logic O_HOST_ATTENTION_OUT,
  input wire logic I_HIBERNATE_REQUEST_N,
  // User side
  input wire hsp_byte_s I_TX,
  output logic O_TX_READY,
  output hsp_byte_s O_RX,
  input wire logic I_RX_READY,
  input wire hsp_byte_s I_SPI_TX,
  output hsp_byte_s O_SPI_RX,
  input wire logic I_ATTN_REQ,
  input wire logic I_RATE_WE,
  input wire logic [15:0] I_RATE_DIV,
  output logic O_HIBERNATE
);
  // Two-flop synchronisers for all pin inputs
  logic [5:0] sy1_reg, sy2_reg;
  wire [5:0] pins = {I_HIBERNATE_REQUEST_N, I_SPI_MOSI,
    I_HOST_PORT_SELECT_N, I_SPI_CLK, I_UART_CTS_N, I_UART_RX};
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      // Idle levels, so no false clock edge follows reset
      sy1_reg <= SYNC_RESET;
      sy2_reg <= SYNC_RESET;
    end else begin
      sy1_reg <= pins;
      sy2_reg <= sy1_reg;
    end
  end
  wire rx_s = sy2_reg[0];
  wire cts_n_s = sy2_reg[1];
  wire sck_s = sy2_reg[2];
  wire sel_n_s = sy2_reg[3];
  wire mosi_s = sy2_reg[4];
  wire hib_n_s = sy2_reg[5];

  // Hibernate: low request blocks new UART frames, SPI select and attention; a frame under way runs to its end
  wire hib = ~hib_n_s;
  assign O_HIBERNATE = hib;

  // Bit period divider, default rate after reset
  logic [15:0] div_reg;
  wire [15:0] div_next = (I_RATE_DIV < DIV_FLOOR) ? DIV_FLOOR : I_RATE_DIV;
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) div_reg <= DIV_RESET;
    else if (I_RATE_WE) div_reg <= div_next;
  end

  // Transmitter: start, 8 data LSB first, stop
  hsp_ser_e tst_reg;
  logic [15:0] tcnt_reg;
  logic [3:0] tbit_reg;
  logic [7:0] tsh_reg;
  logic tx_reg;
  wire tend = (tcnt_reg == div_reg - 16'h0001);
  // Accept only when idle and peer clears us
  assign O_TX_READY = (tst_reg == ST_IDLE) & ~cts_n_s & ~hib;
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      tst_reg <= ST_IDLE;
      tcnt_reg <= 16'h0000;
      tbit_reg <= 4'h0;
      tsh_reg <= 8'h00;
      tx_reg <= 1'b1;
    end else begin
      tcnt_reg <= (tst_reg == ST_IDLE || tend) ? 16'h0000 :
        tcnt_reg + 16'h0001;
      unique case (tst_reg)
        ST_IDLE: if (O_TX_READY && I_TX.valid) begin
          tsh_reg <= I_TX.data;
          tx_reg <= 1'b0;
          tst_reg <= ST_START;
        end
        ST_START: if (tend) begin
          tx_reg <= tsh_reg[0]; // LSB first
          tbit_reg <= 4'h0;
          tst_reg <= ST_DATA;
        end
        ST_DATA: if (tend) begin
          if (tbit_reg == LAST_BIT) begin
            tx_reg <= 1'b1;
            tst_reg <= ST_STOP;
          end else begin
            tx_reg <= tsh_reg[tbit_reg[2:0] + 3'h1];
            tbit_reg <= tbit_reg + 4'h1;
          end
        end
        ST_STOP: if (tend) tst_reg <= ST_IDLE; // One stop bit
      endcase
    end
  end
  assign O_UART_TX = tx_reg;

  // Receiver: mid-bit sampling, no parity
  hsp_ser_e rst_reg;
  logic [15:0] rcnt_reg;
  logic [3:0] rbit_reg;
  logic [7:0] rsh_reg;
  hsp_byte_s rx_reg;
  wire rend = (rcnt_reg == div_reg - 16'h0001);
  wire rmid = (rcnt_reg == {1'b0, div_reg[15:1]});
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      rst_reg <= ST_IDLE;
      rcnt_reg <= 16'h0000;
      rbit_reg <= 4'h0;
      rsh_reg <= 8'h00;
      rx_reg <= '0;
    end else begin
      // Held byte leaves on user handshake
      if (rx_reg.valid && I_RX_READY) rx_reg.valid <= 1'b0;
      rcnt_reg <= (rst_reg == ST_IDLE || rend) ? 16'h0000 :
        rcnt_reg + 16'h0001;
      unique case (rst_reg)
        ST_IDLE: if (!rx_s && !hib) rst_reg <= ST_START;
        ST_START: begin
          if (rmid && rx_s) rst_reg <= ST_IDLE; // Glitch, not a start
          else if (rend) begin
            rbit_reg <= 4'h0;
            rst_reg <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (rmid) rsh_reg <= {rx_s, rsh_reg[7:1]}; // LSB first
          if (rend) begin
            if (rbit_reg == LAST_BIT) rst_reg <= ST_STOP;
            else rbit_reg <= rbit_reg + 4'h1;
          end
        end
        ST_STOP: if (rmid) begin
          if (rx_s) begin
            rx_reg.data <= rsh_reg;
            rx_reg.valid <= 1'b1;
          end
          rst_reg <= ST_IDLE; // Framing error drops byte
        end
      endcase
    end
  end
  assign O_RX = rx_reg;
  // Hold off peer while a byte waits
  assign O_UART_RTS_N = rx_reg.valid | hib;

  // SPI slave, mode 0: sample on rise, shift on fall
  logic sck_d_reg;
  logic [2:0] sbit_reg;
  logic [7:0] sin_reg, sout_reg;
  hsp_byte_s srx_reg;
  wire sck_rise = sck_s & ~sck_d_reg;
  wire sck_fall = ~sck_s & sck_d_reg;
  wire sel = ~sel_n_s & ~hib; // Select is active low
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      sck_d_reg <= 1'b0;
      sbit_reg <= 3'h0;
      sin_reg <= 8'h00;
      sout_reg <= 8'h00;
      srx_reg <= '0;
    end else begin
      sck_d_reg <= sck_s;
      srx_reg.valid <= 1'b0;
      if (!sel) begin
        sbit_reg <= 3'h0;
        sout_reg <= I_SPI_TX.valid ? I_SPI_TX.data : 8'h00;
      end else if (sck_rise) begin
        sin_reg <= {sin_reg[6:0], mosi_s}; // MOSI
        sbit_reg <= sbit_reg + 3'h1;
        if (sbit_reg == 3'h7) begin
          srx_reg.data <= {sin_reg[6:0], mosi_s};
          srx_reg.valid <= 1'b1;
        end
      end else if (sck_fall) begin
        sout_reg <= (sbit_reg == 3'h0 && I_SPI_TX.valid) ?
          I_SPI_TX.data : {sout_reg[6:0], 1'b0};
      end
    end
  end
  assign O_SPI_RX = srx_reg;
  assign O_SPI_MISO = sout_reg[7]; // Device drives MISO

  // Attention: high level until host selects or hibernate is requested
  logic attn_reg;
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) attn_reg <= 1'b0;
    else if (I_ATTN_REQ && !hib) attn_reg <= 1'b1; // Set wins
    else if (sel || hib) attn_reg <= 1'b0;
  end
  assign O_HOST_ATTENTION_OUT = attn_reg;

  // Assertions
  property p_rate_reset;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      $rose(tst_reg == ST_START) |-> ##0 (div_reg >= DIV_FLOOR);
  endproperty
  a_rate_reset: assert property (p_rate_reset)
    else $error("rate divider below floor");
  property p_start_low;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      (tst_reg == ST_START) |-> !O_UART_TX;
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("start bit not low");
  property p_stop_high;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      (tst_reg == ST_STOP) |-> O_UART_TX;
  endproperty
  a_stop_high: assert property (p_stop_high)
    else $error("stop bit not high");
  // Byte taken, then start bit on the line
  sequence s_tx_take;
    O_TX_READY && I_TX.valid;
  endsequence
  sequence s_start_out;
    (tst_reg == ST_START) && !O_UART_TX;
  endsequence
  property p_tx_take;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      s_tx_take |=> s_start_out;
  endproperty
  a_tx_take: assert property (p_tx_take)
    else $error("start bit missing after take");
  property p_attn_set;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      (I_ATTN_REQ && !hib) |=> O_HOST_ATTENTION_OUT;
  endproperty
  a_attn_set: assert property (p_attn_set)
    else $error("attention not raised");
  property p_hib_quiet;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      hib ##1 hib |-> !O_HOST_ATTENTION_OUT && O_UART_RTS_N && !O_TX_READY;
  endproperty
  a_hib_quiet: assert property (p_hib_quiet)
    else $error("activity during hibernate");
  property p_rts_hold;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      O_RX.valid |-> O_UART_RTS_N;
  endproperty
  a_rts_hold: assert property (p_rts_hold)
    else $error("rts open with byte pending");
  property p_miso_idle;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      (!sel && !I_SPI_TX.valid) |=> !O_SPI_MISO;
  endproperty
  a_miso_idle: assert property (p_miso_idle)
    else $error("miso busy while deselected");
  property p_default_rate;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      !I_RATE_WE |=> $stable(div_reg);
  endproperty
  a_default_rate: assert property (p_default_rate)
    else $error("rate changed without command");
endmodule

// >>> include/hsp_pkg.sv
package hsp_pkg;
  // Clock and rate figures
  localparam int unsigned CLK_HZ = 250_000_000; // Core clock rate
  localparam int unsigned BAUD_DEFAULT = 115200; // Start-up line rate
  localparam int unsigned BAUD_MAX = 3_000_000; // Highest raised rate
  // Cycles per bit, rounded down
  localparam int unsigned DIV_DEFAULT = CLK_HZ / BAUD_DEFAULT;
  localparam int unsigned DIV_MIN = CLK_HZ / BAUD_MAX;
  localparam int DIV_W = 16; // Divider register width
  localparam logic [15:0] DIV_RESET = 16'(DIV_DEFAULT);
  localparam logic [15:0] DIV_FLOOR = 16'(DIV_MIN);
  // Character format
  localparam int DATA_BITS = 8; // Data bits per character
  localparam logic [3:0] LAST_BIT = 4'h7; // Index of final data bit
  // Synchroniser reset: pins idle, SPI clock low, no hibernate
  localparam logic [5:0] SYNC_RESET = 6'h3B;
  // Byte with valid, carried between block and user logic
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } hsp_byte_s;
  // Serial-side states
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} hsp_ser_e;
endpackage

// >>> test/hsp_host.sv
`timescale 1ns/10ps
// Host controller model: UART sender and SPI master
module hsp_host (
  // Clock
  input wire logic i_clk,
  // UART lines
  output logic o_rx,
  input wire logic i_rts_n,
  // SPI lines
  output logic o_sck,
  output logic o_sel_n,
  output logic o_mosi,
  input wire logic i_miso
);
  // Idle levels: line high, clock still, deselected
  initial begin
    o_rx = 1'b1;
    o_sck = 1'b0;
    o_sel_n = 1'b1;
    o_mosi = 1'b0;
  end
  // One 8N1 character, LSB first, held off while RTS high
  task automatic send(input int div, input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    while (i_rts_n) @(negedge i_clk);
    for (int i = 0; i < 10; i++) begin
      @(negedge i_clk) o_rx = f[i];
      repeat (div - 1) @(negedge i_clk);
    end
  endtask
  // One SPI byte, mode 0, 56 ns period stays under 20 MHz
  task automatic xfer(input logic [7:0] b, output logic [7:0] r);
    @(negedge i_clk) o_sel_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      o_mosi = b[i];
      repeat (7) @(negedge i_clk);
      o_sck = 1'b1;
      r[i] = i_miso;
      repeat (7) @(negedge i_clk);
      o_sck = 1'b0;
    end
    repeat (7) @(negedge i_clk);
    o_sel_n = 1'b1;
    // Released data line must not keep its last value
    o_mosi = ~o_mosi;
  endtask
endmodule

// >>> test/hsp_top_test.sv
`timescale 1ns/10ps
// Self-checking bench for the host serial port
module hsp_top_test
  import hsp_pkg::*;
;
  logic clk, rst, rx, tx, cts_n, rts_n, sck, sel_n, mosi, miso, attn;
  logic hib_n, tx_rdy, rx_rdy, attn_req, rate_we, hib;
  logic [15:0] rate_div;
  hsp_byte_s tx_b, rx_b, stx_b, srx_b;
  logic [7:0] spi_got, hr;
  int n_fail, num_checks;
  // Device under test
  hsp_top u_hsp_top (.I_MCLK(clk), .I_SYS_RST(rst), .I_UART_RX(rx),
    .O_UART_TX(tx), .I_UART_CTS_N(cts_n), .O_UART_RTS_N(rts_n),
    .I_SPI_CLK(sck), .I_HOST_PORT_SELECT_N(sel_n), .I_SPI_MOSI(mosi),
    .O_SPI_MISO(miso), .O_HOST_ATTENTION_OUT(attn),
    .I_HIBERNATE_REQUEST_N(hib_n), .I_TX(tx_b), .O_TX_READY(tx_rdy),
    .O_RX(rx_b), .I_RX_READY(rx_rdy), .I_SPI_TX(stx_b), .O_SPI_RX(srx_b),
    .I_ATTN_REQ(attn_req), .I_RATE_WE(rate_we), .I_RATE_DIV(rate_div),
    .O_HIBERNATE(hib));
  // Host side model
  hsp_host u_hsp_host (.i_clk(clk), .o_rx(rx), .i_rts_n(rts_n),
    .o_sck(sck), .o_sel_n(sel_n), .o_mosi(mosi), .i_miso(miso));
  // Capture the one-cycle SPI byte pulse
  always @(posedge clk) begin
    if (srx_b.valid === 1'b1) spi_got <= srx_b.data;
  end
  // Compare and count
  task automatic chk(input string nm, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Verdict and end of run
  task automatic results;
    if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Send a byte and sample the line at each mid-bit
  task automatic t_uart_tx(input int div, input logic [7:0] b);
    logic [9:0] s;
    int n;
    n = 0;
    @(negedge clk) tx_b = '{1'b1, b};
    while (tx === 1'b1 && n < 3 * div) @(negedge clk) n++;
    tx_b.valid = 1'b0;
    repeat (div / 2) @(negedge clk);
    for (int i = 0; i < 10; i++) begin
      s[i] = tx; // Host awake for every bit
      repeat (div) @(negedge clk);
    end
    chk("tx frame", 8'h02, {6'h0, s[9], s[0]});
    chk("tx data", b, s[8:1]);
  endtask
  // Clear-to-send high holds the character back
  task automatic t_cts;
    @(negedge clk) cts_n = 1'b1;
    // Let the synchronised clear-to-send settle first
    repeat (3) @(negedge clk);
    tx_b = '{1'b1, 8'hA5};
    repeat (100) @(negedge clk);
    chk("cts hold", 8'h01, {6'h0, tx_rdy, tx});
    tx_b.valid = 1'b0;
    cts_n = 1'b0;
  endtask
  // Raised rate both ways, RTS high while a byte waits
  task automatic t_rate;
    @(negedge clk) rate_we = 1'b1;
    rate_div = DIV_FLOOR - 16'h0001; // Below floor, clamped to fastest
    @(negedge clk) rate_we = 1'b0;
    t_uart_tx(DIV_MIN, 8'h3C);
    u_hsp_host.send(DIV_MIN, 8'hD2);
    repeat (10) @(negedge clk);
    chk("rx data", 8'hD2, rx_b.data);
    chk("rx flags", 8'h11, {3'h0, rx_b.valid, 3'h0, rts_n});
    rx_rdy = 1'b1;
    @(negedge clk) rx_rdy = 1'b0;
    @(negedge clk) chk("rx free", 8'h00, {7'h0, rts_n});
  endtask
  // SPI byte both ways, MSB first
  task automatic t_spi;
    @(negedge clk) stx_b = '{1'b1, 8'hC3};
    u_hsp_host.xfer(8'h5A, hr);
    chk("spi in", 8'h5A, spi_got);
    chk("spi out", 8'hC3, hr);
  endtask
  // Attention raised on request, dropped once host selects
  task automatic t_attn;
    @(negedge clk) attn_req = 1'b1;
    @(negedge clk) attn_req = 1'b0;
    repeat (2) @(negedge clk);
    chk("attn up", 8'h01, {7'h0, attn});
    t_spi;
    chk("attn down", 8'h00, {7'h0, attn});
  endtask
  // Hibernate request stops traffic
  task automatic t_hib;
    @(negedge clk) hib_n = 1'b0;
    repeat (5) @(negedge clk);
    chk("hib", 8'h11, {3'h0, hib, 2'h0, tx_rdy, rts_n});
    hib_n = 1'b1;
  endtask
  // Clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    cts_n = 1'b0;
    hib_n = 1'b1;
    tx_b = '0;
    stx_b = '0;
    rx_rdy = 1'b0;
    attn_req = 1'b0;
    rate_we = 1'b0;
    rate_div = DIV_RESET;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk("reset pins", 8'h01, {4'h0, attn, srx_b.valid, rx_b.valid, tx});
    t_uart_tx(DIV_DEFAULT, 8'h96);
    t_cts;
    t_rate;
    t_attn;
    t_hib;
    results;
  end
  // Watchdog, well past the expected run
  initial begin
    #240000;
    n_fail++;
    results;
  end
endmodule
